/* File: rtl/dsr_defines.svh */
`ifndef DSR_DEFINES_SVH
`define DSR_DEFINES_SVH

// ==========================================================
// register byte offsets
`define DSR_OFF_CTRL 8'h00
`define DSR_OFF_TARGET 8'h04
`define DSR_OFF_STATUS 8'h08
`define DSR_OFF_APPLIED 8'h0c
`define DSR_OFF_IRQ_STAT 8'h10
`define DSR_OFF_IRQ_CLR 8'h14
`define DSR_OFF_IRQ_EN 8'h18

// ==========================================================
// control, status and interrupt field positions
`define DSR_CTRL_EN_BIT 0
`define DSR_CTRL_RATE_LSB 1
`define DSR_CTRL_RATE_MSB 4
`define DSR_CTRL_INC_LSB 5
`define DSR_CTRL_INC_MSB 7
`define DSR_STAT_ACTIVE_BIT 1
`define DSR_IRQ_DONE_BIT 0
`define DSR_IRQ_HALT_BIT 1

// ==========================================================
// reset values and fixed figures
`define DSR_CTRL_RESET 8'h00
`define DSR_TARGET_RESET 16'h0000
`define DSR_IRQ_RESET 2'h0
`define DSR_FRAC_BITS 4
`define DSR_RESP_OKAY 2'h0
`define DSR_RESP_SLVERR 2'h2

// ==========================================================
// update clock frequencies in Hz, rate codes 0 to 15
`define DSR_F0 257730
`define DSR_F1 198410
`define DSR_F2 152440
`define DSR_F3 131580
`define DSR_F4 115740
`define DSR_F5 69440
`define DSR_F6 37590
`define DSR_F7 25770
`define DSR_F8 20160
`define DSR_F9 16030
`define DSR_F10 10290
`define DSR_F11 8280
`define DSR_F12 6900
`define DSR_F13 5530
`define DSR_F14 4240
`define DSR_F15 3300
`define DSR_CLK_HZ 25000000

`endif

/* File: rtl/dsr_pkg.sv */
`default_nettype none
package dsr_pkg;
    typedef struct packed {
        logic [2:0] inc_sel;
        logic [3:0] rate_sel;
        logic ramp_enable_bit;
    } dsr_ctrl_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } dsr_wr_type;
endpackage
`default_nettype wire

/* File: rtl/dsr_slew_ramp.sv */
// Summary of operation
// - ramp disabled: a newly loaded code is applied at once.
// - ramp enabled: applied code walks toward the target in discrete steps.
// - one ramp step per update tick; tick rate chosen by rate select.
// - each tick changes the applied code by the chosen increment; the last step only closes the remaining gap.
// - increment is a power of two; 12-bit variant uses fractional steps.
// - sixteen fixed update frequencies, 257730 Hz down to 3300 Hz.
// - ramp time equals change over step size, frequency and lsb weight.
// - every output change is ramped while ramping is enabled.
// - zeroing input ramps the output to zero at the programmed rate.
// - a control write during a ramp freezes the output where it stands; here a held zeroing input sends it on to zero from the next cycle.
// - tick frequency for a rate code does not depend on output range.
// - ramp active status bit stays high while the output is stepping.
// - new target takes effect on the rising edge of the update strobe.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dsr_defines.svh"

module dsr_slew_ramp
    import dsr_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter bit FRAC_STEPS = 1'b0,
    parameter int CLK_FREQ_HZ = `DSR_CLK_HZ
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic update_strobe,
    input wire logic zero_request,
    // converter side
    output logic [DATA_W-1:0] applied_code,
    output logic ramp_active,
    output logic irq
);

    localparam int ACC_W = DATA_W + `DSR_FRAC_BITS;
    localparam int DIV_W = 24;

    // ==========================================================
    // functions
    // divider reload depends only on the rate code, never on output range
    function automatic logic [DIV_W-1:0] rate_divisor(input logic [3:0] sel);
        int f;
        int d;
        case (sel)
            4'h0: f = `DSR_F0;
            4'h1: f = `DSR_F1;
            4'h2: f = `DSR_F2;
            4'h3: f = `DSR_F3;
            4'h4: f = `DSR_F4;
            4'h5: f = `DSR_F5;
            4'h6: f = `DSR_F6;
            4'h7: f = `DSR_F7;
            4'h8: f = `DSR_F8;
            4'h9: f = `DSR_F9;
            4'ha: f = `DSR_F10;
            4'hb: f = `DSR_F11;
            4'hc: f = `DSR_F12;
            4'hd: f = `DSR_F13;
            4'he: f = `DSR_F14;
            default: f = `DSR_F15;
        endcase
        // the period for each rate code rounds down, never below one cycle
        d = CLK_FREQ_HZ / f;
        if (d < 1) begin
            d = 1;
        end
        return DIV_W'(d - 1);
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input dsr_wr_type w);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (w.strb[i]) begin
                r[i*8 +: 8] = w.data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // pin synchronisers
    logic [1:0] strobe_sync_reg;
    logic [1:0] zero_sync_reg;
    logic strobe_last_reg;
    wire strobe_rise = strobe_sync_reg[1] & ~strobe_last_reg;
    wire zero_level = zero_sync_reg[1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strobe_sync_reg <= 2'h0;
            zero_sync_reg <= 2'h0;
            strobe_last_reg <= 1'b0;
        end else if (clk_en) begin
            strobe_sync_reg <= {strobe_sync_reg[0], update_strobe};
            zero_sync_reg <= {zero_sync_reg[0], zero_request};
            strobe_last_reg <= strobe_sync_reg[1];
        end
    end

    // ==========================================================
    // axi4-lite write channel
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire = s_axi_wvalid & s_axi_wready;
    wire aw_have = aw_held_reg | aw_fire;
    wire w_have = w_held_reg | w_fire;
    wire wr_do = aw_have & w_have & ~bvalid_reg & clk_en;

    dsr_wr_type wr;
    assign wr.addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    assign wr.data = w_held_reg ? wdata_reg : s_axi_wdata;
    assign wr.strb = w_held_reg ? wstrb_reg : s_axi_wstrb;

    wire wr_ctrl = wr_do & (wr.addr == `DSR_OFF_CTRL);
    wire wr_target = wr_do & (wr.addr == `DSR_OFF_TARGET);
    wire wr_iclr = wr_do & (wr.addr == `DSR_OFF_IRQ_CLR);
    wire wr_ien = wr_do & (wr.addr == `DSR_OFF_IRQ_EN);
    wire wr_known = wr_ctrl | wr_target | wr_iclr | wr_ien;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `DSR_RESP_OKAY;
        end else if (clk_en) begin
            if (aw_fire) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_fire) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_known ? `DSR_RESP_OKAY : `DSR_RESP_SLVERR;
            end else begin
                aw_held_reg <= aw_have;
                w_held_reg <= w_have;
                if (s_axi_bready) begin
                    bvalid_reg <= 1'b0;
                end
            end
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ==========================================================
    // software registers
    dsr_ctrl_type ctrl_reg;
    logic [DATA_W-1:0] pending_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_en_reg;
    logic [31:0] ctrl_merge;
    logic [31:0] target_merge;
    logic [31:0] ien_merge;

    assign ctrl_merge = merge_strb(32'(ctrl_reg), wr);
    assign target_merge = merge_strb(32'(pending_reg), wr);
    assign ien_merge = merge_strb(32'(irq_en_reg), wr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= dsr_ctrl_type'(`DSR_CTRL_RESET);
            pending_reg <= DATA_W'(`DSR_TARGET_RESET);
            irq_en_reg <= `DSR_IRQ_RESET;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                ctrl_reg <= dsr_ctrl_type'(ctrl_merge[`DSR_CTRL_INC_MSB:`DSR_CTRL_EN_BIT]);
            end
            if (wr_target) begin
                pending_reg <= target_merge[DATA_W-1:0];
            end
            if (wr_ien) begin
                irq_en_reg <= ien_merge[1:0];
            end
        end
    end

    // ==========================================================
    // update tick divider, free running
    logic [DIV_W-1:0] div_cnt_reg;
    wire tick = (div_cnt_reg == '0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_reg <= '0;
        end else if (clk_en) begin
            // reload reads the rate code only here, so a change lands next tick
            div_cnt_reg <= tick ? rate_divisor(ctrl_reg.rate_sel) : div_cnt_reg - 1'b1;
        end
    end

    // ==========================================================
    // ramp engine: accumulator carries fractional bits for the small steps
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] goal_reg;
    logic [ACC_W-1:0] step;
    logic [ACC_W-1:0] gap;
    logic [ACC_W-1:0] acc_stepped;
    logic [ACC_W-1:0] goal_next;
    logic load_now;
    logic moving;

    // power of two step; the 16-bit variant sits four places higher
    assign step = FRAC_STEPS ? (ACC_W'(1) << ctrl_reg.inc_sel)
                             : (ACC_W'(1) << (4'(ctrl_reg.inc_sel) + 4'(`DSR_FRAC_BITS)));
    assign moving = (acc_reg != goal_reg);
    assign gap = (goal_reg > acc_reg) ? goal_reg - acc_reg : acc_reg - goal_reg;
    // clamp the final step onto the goal, no overshoot
    assign acc_stepped = (gap <= step) ? goal_reg
                       : (goal_reg > acc_reg) ? acc_reg + step : acc_reg - step;

    // zeroing holds off new loads; a strobe afterwards restores the held code
    assign load_now = strobe_rise & ~zero_level;
    assign goal_next = zero_level ? '0
                     : load_now ? {pending_reg, `DSR_FRAC_BITS'(0)} : goal_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_reg <= '0;
            goal_reg <= '0;
        end else if (clk_en) begin
            if (wr_ctrl && moving) begin
                // halt at the intermediate value
                goal_reg <= acc_reg;
            end else if (!ctrl_reg.ramp_enable_bit) begin
                goal_reg <= goal_next;
                acc_reg <= goal_next;
            end else begin
                // every change, zeroing included, goes through the ramp
                goal_reg <= goal_next;
                if (tick && moving) begin
                    acc_reg <= acc_stepped;
                end
            end
        end
    end

    // ==========================================================
    // event flags: set wins over clear
    logic moving_last_reg;
    wire ev_done = moving_last_reg & ~moving & ~(wr_ctrl & moving);
    wire ev_halt = wr_ctrl & moving;
    logic [31:0] iclr_merge;
    assign iclr_merge = merge_strb(32'h0, wr);
    wire [1:0] clr_bits = wr_iclr ? iclr_merge[1:0] : 2'h0;
    wire [1:0] set_bits = {ev_halt, ev_done};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            moving_last_reg <= 1'b0;
            irq_stat_reg <= `DSR_IRQ_RESET;
        end else if (clk_en) begin
            moving_last_reg <= moving;
            irq_stat_reg <= (irq_stat_reg & ~clr_bits) | set_bits;
        end
    end

    assign irq = |(irq_stat_reg & irq_en_reg);
    assign applied_code = acc_reg[ACC_W-1:`DSR_FRAC_BITS];
    assign ramp_active = moving;

    // ==========================================================
    // axi4-lite read channel
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rd_value;
    logic rd_known;

    assign s_axi_arready = ~rvalid_reg;
    wire ar_fire = s_axi_arvalid & s_axi_arready & clk_en;

    always_comb begin
        rd_value = 32'h0;
        rd_known = 1'b1;
        case (s_axi_araddr)
            `DSR_OFF_CTRL: rd_value = 32'(ctrl_reg);
            `DSR_OFF_TARGET: rd_value = 32'(pending_reg);
            `DSR_OFF_STATUS: rd_value = 32'(moving) << `DSR_STAT_ACTIVE_BIT;
            `DSR_OFF_APPLIED: rd_value = 32'(applied_code);
            `DSR_OFF_IRQ_STAT: rd_value = 32'(irq_stat_reg);
            `DSR_OFF_IRQ_CLR: rd_value = 32'h0;
            `DSR_OFF_IRQ_EN: rd_value = 32'(irq_en_reg);
            default: rd_known = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= `DSR_RESP_OKAY;
        end else if (clk_en) begin
            if (ar_fire) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_value;
                rresp_reg <= rd_known ? `DSR_RESP_OKAY : `DSR_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

endmodule

`default_nettype wire

/* File: tb/dsr_slew_ramp_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// port checks
module dsr_slew_ramp_asserts #(
    parameter int DATA_W = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // converter side
    input wire logic [DATA_W-1:0] applied_code,
    input wire logic ramp_active,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_resp_clear: assert property (clk_en && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response stayed after it was taken");
    a_rvalid_clear: assert property (clk_en && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data stayed after it was taken");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    a_read_answer: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_write_answer: assert property (clk_en && s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    a_slverr_read: assert property (clk_en && s_axi_arvalid && s_axi_arready
        && s_axi_araddr > 8'h18 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    // a ramp step is followed by at least one quiet cycle while the ramp is still running
    a_step_spacing: assert property ($changed(applied_code) && ramp_active |=> !$changed(applied_code))
        else $error("output stepped on two consecutive cycles during a ramp");

    cover property ($fell(ramp_active));
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cover property ($rose(irq));
endmodule

bind dsr_slew_ramp dsr_slew_ramp_asserts #(.DATA_W(DATA_W)) chk_i (
    .aclk, .aresetn, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .applied_code, .ramp_active, .irq
);
`default_nettype wire

/* File: tb/dsr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// host model, bus master
module dsr_host_model (
    // clock and status
    input wire logic aclk,
    input wire logic ramp_active,
    // write
    output var logic [7:0] s_axi_awaddr,
    output var logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output var logic [31:0] s_axi_wdata,
    output var logic [3:0] s_axi_wstrb,
    output var logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output var logic s_axi_bready,
    // read
    output var logic [7:0] s_axi_araddr,
    output var logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output var logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    // a polite host waits out a ramp first, since a control write halts it
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input bit polite,
                      output logic [1:0] r);
        bit fin;
        fin = 1'b0;
        r = 2'h3;
        while (polite && ramp_active !== 1'b0) begin
            @(posedge aclk);
        end
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!fin) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                fin = 1'b1;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        bit fin;
        fin = 1'b0;
        v = 32'hx;
        r = 2'hx;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!fin) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                v = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                fin = 1'b1;
            end
        end
    endtask
endmodule
`default_nettype wire

/* File: tb/dac_output_slew_ramp_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dsr_defines.svh"
module dac_output_slew_ramp_test;
    import dsr_pkg::*;
    // slow timebase keeps ticks short: rate 0 is 10 cycles, rate 1 is 13
    localparam int CLKF = 2600000;
    localparam int PER0 = CLKF / `DSR_F0;
    localparam int PER1 = CLKF / `DSR_F1;
    logic aclk, aresetn, clk_en, update_strobe, zero_request;
    wire logic [7:0] s_axi_awaddr, s_axi_araddr;
    wire logic [31:0] s_axi_wdata, s_axi_rdata;
    wire logic [3:0] s_axi_wstrb;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    wire logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire logic [15:0] applied_code;
    wire logic ramp_active, irq;
    int n_errors = 0;
    int checked = 0;
    logic [31:0] d;
    logic [1:0] r;

    dsr_slew_ramp #(.CLK_FREQ_HZ(CLKF)) uut (
        .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .update_strobe,
        .zero_request, .applied_code, .ramp_active, .irq
    );
    dsr_host_model host (
        .aclk, .ramp_active, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // ==========
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic w(input logic [7:0] a, input logic [31:0] v);
        host.wr(a, v, 1'b1, r);
        chk(r, `DSR_RESP_OKAY);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        host.rd(a, d, r);
        chk(d, e);
    endtask

    // loads a goal by strobe or zero pin, then follows every step to the end
    task automatic ramp(input logic [15:0] tgt, input int step, per, nst, input bit z);
        logic [15:0] prev;
        int last, n, k, dl;
        prev = applied_code;
        last = -1;
        k = 0;
        for (n = 0; n < nst * per + 60 && k < nst; n++) begin
            @(posedge aclk);
            if (n == 0 && z) zero_request <= 1'b1;
            update_strobe <= (n < 4 && !z);
            #1;
            if (applied_code !== prev) begin
                dl = (tgt > prev) ? tgt - prev : prev - tgt;
                if (dl > step) dl = step;
                chk(applied_code, (tgt > prev) ? prev + dl : prev - dl);
                if (last >= 0) chk(n - last, per);
                if (applied_code !== tgt) chk(ramp_active, 1'b1);
                last = n;
                prev = applied_code;
                k++;
            end
        end
        chk(k, nst);
        @(posedge aclk);
        update_strobe <= 1'b0;
        #1;
        chk(applied_code, tgt);
        chk(ramp_active, 1'b0);
    endtask

    // ==========
    // scenarios
    task automatic t_reset;
        rc(`DSR_OFF_CTRL, 32'h0);
        rc(`DSR_OFF_TARGET, 32'h0);
        rc(`DSR_OFF_APPLIED, 32'h0);
        rc(`DSR_OFF_IRQ_EN, 32'h0);
        rc(`DSR_OFF_STATUS, 32'h0);
        rc(`DSR_OFF_IRQ_STAT, 32'h0);
        rc(8'h40, 32'h0);
        chk(r, `DSR_RESP_SLVERR);
        w(`DSR_OFF_IRQ_CLR, 32'h3);
        rc(`DSR_OFF_IRQ_CLR, 32'h0);
        chk(irq, 1'b0);
    endtask

    task automatic t_direct;
        w(`DSR_OFF_TARGET, 32'h1234);
        rc(`DSR_OFF_APPLIED, 32'h0);
        ramp(16'h1234, 65536, 0, 1, 1'b0);
    endtask

    task automatic t_ramp;
        w(`DSR_OFF_CTRL, 32'h61);
        rc(`DSR_OFF_CTRL, 32'h61);
        w(`DSR_OFF_TARGET, 32'h1248);
        ramp(16'h1248, 8, PER0, 3, 1'b0);
        chk(irq, 1'b0);
        rc(`DSR_OFF_IRQ_STAT, 32'h1);
        w(`DSR_OFF_IRQ_EN, 32'h1);
        chk(irq, 1'b1);
        w(`DSR_OFF_IRQ_CLR, 32'h1);
        chk(irq, 1'b0);
    endtask

    task automatic t_zero;
        w(`DSR_OFF_CTRL, 32'he3);
        ramp(16'h0, 128, PER1, 37, 1'b1);
        zero_request <= 1'b0;
    endtask

    task automatic t_halt;
        w(`DSR_OFF_IRQ_EN, 32'h2);
        w(`DSR_OFF_CTRL, 32'h61);
        w(`DSR_OFF_TARGET, 32'h1000);
        @(posedge aclk);
        update_strobe <= 1'b1;
        repeat (60) @(posedge aclk);
        update_strobe <= 1'b0;
        rc(`DSR_OFF_STATUS, 32'h2);
        host.wr(`DSR_OFF_CTRL, 32'h61, 1'b0, r);
        #1;
        d = applied_code;
        repeat (3 * PER0) @(posedge aclk);
        #1;
        chk(applied_code, d);
        chk(ramp_active, 1'b0);
        rc(`DSR_OFF_STATUS, 32'h0);
        chk(irq, 1'b1);
        w(`DSR_OFF_IRQ_CLR, 32'h2);
        chk(irq, 1'b0);
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (10000) @(posedge aclk);
        n_errors++;
        summarize;
    end

    initial begin
        aresetn = 1'b0;
        clk_en = 1'b1;
        update_strobe = 1'b0;
        zero_request = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_direct;
        t_ramp;
        t_zero;
        t_halt;
        summarize;
    end
endmodule
`default_nettype wire
